// ---- verilog/bct_cpu.sv ----
`timescale 1ns/1ns
// Notes on behaviour
// - Read data captured on final falling edge.
// - Write data held past data strobe negation.
// - Responder never mixes both termination styles.
// - Sync cycles two clocks, async three minimum.
// - Port acknowledge lines end async cycles.
// - Port acknowledge synchronised before use.
// - Sync termination sampled directly, unsynchronised.
// - Sync termination held valid every rising edge.
// - Sync termination accepted only during address strobe.
// - Cycles may abort before address strobe.
// - Cache read hits finish without external bus cycle.
// - Burst moves four long words in five clocks.
module bct_cpu
    import bct_pkg::*;
(
    // Clock and reset.
    input wire logic mclk_in,
    input wire logic reset_in,
    // Access request from the core.
    input wire logic req_valid_in,
    input wire logic req_write_in,
    input wire logic req_burst_in,
    input wire logic req_abort_in,
    input wire logic [bct_pkg::ADDR_W-1:0] req_addr_in,
    input wire logic [bct_pkg::DATA_W-1:0] req_wdata_in,
    input wire logic cache_hit_in,
    input wire logic [bct_pkg::DATA_W-1:0] cache_data_in,
    output logic req_ready_out,
    // Access completion.
    output logic done_out,
    output logic aborted_out,
    output logic cache_done_out,
    output logic [bct_pkg::DATA_W-1:0] rdata_out,
    output logic [1:0] beat_out,
    output logic [bct_pkg::CNT_W-1:0] clocks_out,
    output logic [bct_pkg::CNT_W-1:0] waits_out,
    // Bus side.
    bct_if.cpu bus
);
    import bct_pkg::*;

    bct_state_t state, next_state;
    logic [CNT_W-1:0] clk_cnt, next_clk_cnt;
    logic [1:0] beat, next_beat;
    logic [ADDR_W-1:0] addr, next_addr;
    logic [DATA_W-1:0] wdata, next_wdata;
    logic rw_write, next_rw_write;
    logic burst, next_burst;
    logic [1:0] ack_meta, ack_sync;
    logic [DATA_W-1:0] rd_latch;
    logic term_async, term_sync, min_ok, term_hit;
    logic [CNT_W-1:0] min_clks;

    // Port acknowledge passes two flops before any decision uses it.
    always_ff @(posedge mclk_in or posedge reset_in) begin
        if (reset_in) begin
            ack_meta <= ACK_NONE;
            ack_sync <= ACK_NONE;
        end else begin
            ack_meta <= bus.async_port_ack;
            ack_sync <= ack_meta;
        end
    end

    // Termination decode: either ack bit ends async, sync input is used raw.
    always_comb begin
        term_async = (ack_sync != ACK_NONE);
        term_sync = bus.sync_cycle_term;
        min_clks = term_sync ? CNT_W'(SYNC_MIN_CLKS) : CNT_W'(ASYNC_MIN_CLKS);
        min_ok = (clk_cnt + CNT_ONE) >= min_clks;
        term_hit = (term_sync || term_async) && min_ok;
    end

    // Read data is latched at the falling edge within the final clock.
    always_ff @(negedge mclk_in or posedge reset_in) begin
        if (reset_in) begin
            rd_latch <= DATA_RESET;
        end else if ((state == BCT_STROBE || state == BCT_WAIT) && term_hit) begin
            rd_latch <= bus.rdata;
        end
    end

    // Sequencer next-state logic.
    always_comb begin
        next_state = state;
        next_clk_cnt = clk_cnt;
        next_beat = beat;
        next_addr = addr;
        next_wdata = wdata;
        next_rw_write = rw_write;
        next_burst = burst;
        case (state)
            BCT_IDLE: begin
                if (req_valid_in && !(cache_hit_in && !req_write_in)) begin
                    next_state = BCT_START;
                    next_addr = req_addr_in;
                    next_wdata = req_wdata_in;
                    next_rw_write = req_write_in;
                    next_burst = req_burst_in && !req_write_in;
                    next_clk_cnt = CNT_ZERO;
                    next_beat = 2'h0;
                end
            end
            BCT_START: begin
                // Abort before the address strobe is legal.
                if (req_abort_in) begin
                    next_state = BCT_IDLE;
                end else begin
                    next_state = BCT_STROBE;
                    next_clk_cnt = CNT_ONE;
                end
            end
            BCT_STROBE, BCT_WAIT: begin
                if (term_hit) begin
                    if (burst && bus.burst_ack_in && term_sync &&
                        beat != 2'(BURST_BEATS - 1)) begin
                        next_beat = beat + 2'h1;
                        next_addr = addr + 32'h0000_0004;
                        next_clk_cnt = CNT_ONE;
                        next_state = BCT_WAIT;
                    end else begin
                        next_state = rw_write ? BCT_HOLD : BCT_FINISH;
                    end
                end else begin
                    next_clk_cnt = clk_cnt + CNT_ONE;
                    next_state = BCT_WAIT;
                end
            end
            BCT_HOLD: begin
                next_state = BCT_FINISH;
            end
            BCT_FINISH: begin
                next_state = BCT_IDLE;
            end
            default: begin
                next_state = BCT_IDLE;
            end
        endcase
    end

    // Sequencer registers.
    always_ff @(posedge mclk_in or posedge reset_in) begin
        if (reset_in) begin
            state <= BCT_IDLE;
            clk_cnt <= CNT_ZERO;
            beat <= 2'h0;
            addr <= '0;
            wdata <= DATA_RESET;
            rw_write <= 1'b0;
            burst <= 1'b0;
        end else begin
            state <= next_state;
            clk_cnt <= next_clk_cnt;
            beat <= next_beat;
            addr <= next_addr;
            wdata <= next_wdata;
            rw_write <= next_rw_write;
            burst <= next_burst;
        end
    end

    // Completion reporting, all registered.
    always_ff @(posedge mclk_in or posedge reset_in) begin
        if (reset_in) begin
            done_out <= 1'b0;
            aborted_out <= 1'b0;
            cache_done_out <= 1'b0;
            rdata_out <= DATA_RESET;
            beat_out <= 2'h0;
            clocks_out <= CNT_ZERO;
            waits_out <= CNT_ZERO;
        end else begin
            done_out <= (state == BCT_FINISH);
            aborted_out <= (state == BCT_START) && req_abort_in;
            cache_done_out <= (state == BCT_IDLE) && req_valid_in && cache_hit_in &&
                !req_write_in;
            if (state == BCT_IDLE && req_valid_in && cache_hit_in && !req_write_in) begin
                rdata_out <= cache_data_in;
            end else if (state == BCT_FINISH && !rw_write) begin
                rdata_out <= rd_latch;
            end
            if ((state == BCT_STROBE || state == BCT_WAIT) && term_hit) begin
                beat_out <= beat;
                clocks_out <= clk_cnt + CNT_ONE;
                waits_out <= clk_cnt + CNT_ONE - min_clks;
            end
        end
    end

    // Bus drive; write data stays on through the hold clock after strobes drop.
    always_comb begin
        req_ready_out = (state == BCT_IDLE);
        bus.addr = addr;
        bus.rd_wr = !rw_write;
        bus.early_cycle_start = (state == BCT_START);
        bus.addr_strobe = (state == BCT_STROBE || state == BCT_WAIT);
        bus.data_strobe = (state == BCT_STROBE || state == BCT_WAIT);
        bus.burst_req = burst;
        bus.wdata = wdata;
        bus.wdata_oe = rw_write && (state == BCT_STROBE || state == BCT_WAIT ||
            state == BCT_HOLD);
    end
endmodule

// ---- inc/bct_pkg.sv ----
package bct_pkg;
    // Bus cycle minimum lengths, in processor clock periods.
    localparam int unsigned SYNC_MIN_CLKS = 2;
    localparam int unsigned ASYNC_MIN_CLKS = 3;
    // Burst shape: beats per burst and fewest clocks for a whole burst.
    localparam int unsigned BURST_BEATS = 4;
    localparam int unsigned BURST_MIN_CLKS = 5;
    localparam int unsigned DATA_W = 32;
    localparam int unsigned ADDR_W = 32;
    localparam int unsigned CNT_W = 8;
    // Port acknowledge encodings, active high inside the design.
    localparam logic [1:0] ACK_NONE = 2'h0;
    localparam logic [31:0] DATA_RESET = 32'h0000_0000;
    localparam logic [CNT_W-1:0] CNT_ZERO = 8'h00;
    localparam logic [CNT_W-1:0] CNT_ONE = 8'h01;

    // Processor bus sequencer states.
    typedef enum logic [5:0] {
        BCT_IDLE = 6'b00_0001,
        BCT_START = 6'b00_0010,
        BCT_STROBE = 6'b00_0100,
        BCT_WAIT = 6'b00_1000,
        BCT_FINISH = 6'b01_0000,
        BCT_HOLD = 6'b10_0000
    } bct_state_t;

    // Responder states.
    typedef enum logic [2:0] {
        BCR_IDLE = 3'b001,
        BCR_DELAY = 3'b010,
        BCR_TERM = 3'b100
    } bcr_state_t;
endpackage

// ---- inc/bct_if.sv ----
`timescale 1ns/1ns
// Bus between the processor end and the responder end.
interface bct_if;
    logic [31:0] addr;
    logic rd_wr;
    logic early_cycle_start;
    logic addr_strobe;
    logic data_strobe;
    logic burst_req;
    logic [31:0] wdata;
    logic wdata_oe;
    logic [31:0] rdata;
    logic rdata_oe;
    logic [1:0] async_port_ack;
    logic sync_cycle_term;
    logic burst_ack_in;

    modport cpu (
        output addr, rd_wr, early_cycle_start, addr_strobe, data_strobe, burst_req,
        output wdata, wdata_oe,
        input rdata, rdata_oe, async_port_ack, sync_cycle_term, burst_ack_in
    );
    modport resp (
        input addr, rd_wr, early_cycle_start, addr_strobe, data_strobe, burst_req,
        input wdata, wdata_oe,
        output rdata, rdata_oe, async_port_ack, sync_cycle_term, burst_ack_in
    );
endinterface

// ---- verilog/bct_resp.sv ----
`timescale 1ns/1ns
// Responder end: memory or peripheral control logic.
module bct_resp
    import bct_pkg::*;
(
    // Clock and reset.
    input wire logic mclk_in,
    input wire logic reset_in,
    // User-side configuration.
    input wire logic use_sync_in,
    input wire logic [bct_pkg::CNT_W-1:0] wait_clks_in,
    input wire logic burst_ok_in,
    input wire logic [bct_pkg::DATA_W-1:0] mem_rdata_in,
    // User-side results.
    output logic wr_strobe_out,
    output logic [bct_pkg::ADDR_W-1:0] wr_addr_out,
    output logic [bct_pkg::DATA_W-1:0] wr_data_out,
    // Bus side.
    bct_if.resp bus
);
    import bct_pkg::*;

    bcr_state_t state, next_state;
    logic [CNT_W-1:0] cnt, next_cnt;

    // A cycle is decoded from its early start, so a zero-wait sync cycle ends in two clocks.
    // An abandoned cycle never raises the strobe and drops the responder back to idle.
    always_comb begin
        next_state = state;
        next_cnt = cnt;
        case (state)
            BCR_IDLE: begin
                if (bus.early_cycle_start) begin
                    next_state = (wait_clks_in == CNT_ZERO) ? BCR_TERM : BCR_DELAY;
                    next_cnt = wait_clks_in;
                end
            end
            BCR_DELAY: begin
                next_cnt = cnt - CNT_ONE;
                if (!bus.addr_strobe) begin
                    next_state = BCR_IDLE;
                end else if (cnt == CNT_ONE) begin
                    next_state = BCR_TERM;
                end
            end
            BCR_TERM: begin
                if (!bus.addr_strobe) begin
                    next_state = BCR_IDLE;
                end
            end
            default: begin
                next_state = BCR_IDLE;
            end
        endcase
    end

    // Responder registers and write capture.
    always_ff @(posedge mclk_in or posedge reset_in) begin
        if (reset_in) begin
            state <= BCR_IDLE;
            cnt <= CNT_ZERO;
            wr_strobe_out <= 1'b0;
            wr_addr_out <= '0;
            wr_data_out <= DATA_RESET;
        end else begin
            state <= next_state;
            cnt <= next_cnt;
            wr_strobe_out <= (state == BCR_TERM) && bus.data_strobe && !bus.rd_wr;
            if ((state == BCR_TERM) && bus.data_strobe && !bus.rd_wr) begin
                wr_addr_out <= bus.addr;
                wr_data_out <= bus.wdata;
            end
        end
    end

    // Termination: one style per cycle, sync held low on every other edge.
    always_comb begin
        bus.sync_cycle_term = use_sync_in && (state == BCR_TERM) && bus.addr_strobe;
        bus.async_port_ack = (!use_sync_in && state == BCR_TERM && bus.addr_strobe) ?
            2'h3 : ACK_NONE;
        bus.burst_ack_in = use_sync_in && burst_ok_in && bus.burst_req &&
            (state == BCR_TERM) && bus.addr_strobe;
        bus.rdata = mem_rdata_in;
        bus.rdata_oe = bus.rd_wr && bus.data_strobe;
    end
endmodule

// ---- verification/bct_props.sv ----
`timescale 1ns/1ns
// Watches the bus between the two ends for termination and strobe slips.
module bct_props (
    input wire logic mclk_in,
    input wire logic reset_in,
    input wire logic rd_wr,
    input wire logic early_cycle_start,
    input wire logic addr_strobe,
    input wire logic data_strobe,
    input wire logic wdata_oe,
    input wire logic rdata_oe,
    input wire logic [1:0] async_port_ack,
    input wire logic sync_cycle_term,
    input wire logic burst_ack_in
);
    default clocking @(posedge mclk_in); endclocking
    default disable iff (reset_in);
    // Termination, strobe length and data drive relations.
    no_mixed_term_a: assert property (!((|async_port_ack) && sync_cycle_term))
        else $error("both termination styles in one cycle");
    strobe_start_a: assert property ($rose(addr_strobe) |-> $past(early_cycle_start))
        else $error("address strobe without a start cycle");
    min_length_a: assert property ($fell(addr_strobe) |->
        $past(early_cycle_start, 2) || $past(addr_strobe, 2))
        else $error("bus cycle shorter than two clocks");
    ack_sync_a: assert property ($rose(|async_port_ack) |-> addr_strobe[*3])
        else $error("port acknowledge used before synchronising");
    ack_held_a: assert property ((|async_port_ack) && addr_strobe |=>
        !addr_strobe || (|async_port_ack))
        else $error("port acknowledge dropped before strobe");
    wdata_hold_a: assert property ($fell(data_strobe) && !rd_wr |-> wdata_oe)
        else $error("write data released with the strobe");
    rd_no_drive_a: assert property (rd_wr && data_strobe |-> !wdata_oe)
        else $error("write data driven during a read");
    rdata_qual_a: assert property ($rose(rdata_oe) |-> addr_strobe)
        else $error("read data driven without address strobe");
    burst_sync_a: assert property (burst_ack_in |-> sync_cycle_term)
        else $error("burst acknowledge without sync termination");
    // Main scenarios reached.
    cov_async: cover property ($rose(|async_port_ack));
    cov_write: cover property ($fell(data_strobe) && !rd_wr);
    cov_burst: cover property (burst_ack_in);
endmodule

// ---- verification/bus_cycle_termination_tb.sv ----
`timescale 1ns/1ns
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin errors++; \
    $display("Error at %0t: got %h expected %h", $time, (a), (b)); end end
// Drives random and corner accesses through both ends and checks the results.
module bus_cycle_termination_tb;
    import bct_pkg::*;
    logic mclk_in = 0, reset_in = 1;
    logic req_valid_in = 0, req_write_in = 0, req_burst_in = 0, req_abort_in = 0;
    logic cache_hit_in = 0, use_sync_in = 0, burst_ok_in = 0;
    logic [31:0] req_addr_in = 0, req_wdata_in = 0, cache_data_in = 0, mem_rdata_in = 0;
    logic [7:0] wait_clks_in = 0;
    logic req_ready_out, done_out, aborted_out, cache_done_out, wr_strobe_out;
    logic [31:0] rdata_out, wr_addr_out, wr_data_out, wr_a, wr_d, r;
    logic [1:0] beat_out;
    logic [7:0] clocks_out, waits_out;
    logic seen_as, wr_seen, got_done, got_abort, got_hit;
    int errors = 0, checks = 0;
    bct_if bus_i ();
    bct_cpu i_bct_cpu (.mclk_in(mclk_in), .reset_in(reset_in), .req_valid_in(req_valid_in),
        .req_write_in(req_write_in), .req_burst_in(req_burst_in), .req_abort_in(req_abort_in),
        .req_addr_in(req_addr_in), .req_wdata_in(req_wdata_in), .cache_hit_in(cache_hit_in),
        .cache_data_in(cache_data_in), .req_ready_out(req_ready_out), .done_out(done_out),
        .aborted_out(aborted_out), .cache_done_out(cache_done_out), .rdata_out(rdata_out),
        .beat_out(beat_out), .clocks_out(clocks_out), .waits_out(waits_out), .bus(bus_i));
    bct_resp i_bct_resp (.mclk_in(mclk_in), .reset_in(reset_in), .use_sync_in(use_sync_in),
        .wait_clks_in(wait_clks_in), .burst_ok_in(burst_ok_in), .mem_rdata_in(mem_rdata_in),
        .wr_strobe_out(wr_strobe_out), .wr_addr_out(wr_addr_out), .wr_data_out(wr_data_out),
        .bus(bus_i));
    bct_props i_bct_props (.mclk_in(mclk_in), .reset_in(reset_in), .rd_wr(bus_i.rd_wr),
        .early_cycle_start(bus_i.early_cycle_start), .addr_strobe(bus_i.addr_strobe),
        .data_strobe(bus_i.data_strobe), .wdata_oe(bus_i.wdata_oe), .rdata_oe(bus_i.rdata_oe),
        .async_port_ack(bus_i.async_port_ack), .sync_cycle_term(bus_i.sync_cycle_term),
        .burst_ack_in(bus_i.burst_ack_in));
    // Clock of 40 ns period.
    always #20 mclk_in = ~mclk_in;
    // Records bus activity and responder writes mid-cycle.
    always @(negedge mclk_in) begin
        if (bus_i.addr_strobe === 1'b1) seen_as = 1;
        if (wr_strobe_out === 1'b1) begin
            wr_seen = 1;
            wr_a = wr_addr_out;
            wr_d = wr_data_out;
        end
    end
    // Pseudo-random source.
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], 1'b0} ^ (s[31] ? 32'h0040_0007 : 32'h0000_0000);
    endfunction
    // Expected wait states: an async acknowledge shows first in the strobe clock and
    // then crosses two flops, so it costs one clock beyond the three-clock minimum.
    function automatic logic [7:0] exp_waits(input logic s, input logic [7:0] w);
        return s ? w : w + 8'h01;
    endfunction
    // Expected clocks of a cycle: the style's minimum plus its wait states.
    function automatic logic [7:0] exp_clks(input logic s, input logic [7:0] w);
        return exp_waits(s, w) + (s ? 8'(SYNC_MIN_CLKS) : 8'(ASYNC_MIN_CLKS));
    endfunction
    task automatic end_of_test;
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    // One access: request for one clock, then a bounded wait for its outcome.
    task automatic run(input logic w, input logic b, input logic ab);
        int n;
        @(posedge mclk_in);
        #1;
        {seen_as, wr_seen, got_done, got_abort, got_hit} = 5'h00;
        {req_valid_in, req_write_in, req_burst_in, req_abort_in} = {1'b1, w, b, ab};
        @(posedge mclk_in);
        #1;
        req_valid_in = 0;
        {got_done, got_abort, got_hit} = {done_out, aborted_out, cache_done_out};
        for (n = 0; n < 60 && !(got_done | got_abort | got_hit); n++) begin
            @(posedge mclk_in);
            #1;
            {got_done, got_abort, got_hit} = {done_out, aborted_out, cache_done_out};
        end
        req_abort_in = 0;
        if (n == 60) begin
            errors++;
            end_of_test;
        end
        @(posedge mclk_in);
        #1;
    endtask
    // Main sequence.
    initial begin
        r = 32'h0000_e07a;
        repeat (5) @(posedge mclk_in);
        #1 reset_in = 0;
        for (int i = 0; i < 24; i++) begin
            r = lfsr(r);
            use_sync_in = r[0];
            wait_clks_in = {6'h00, r[2:1]};
            req_addr_in = {r[31:4], 4'h0};
            req_wdata_in = lfsr(r);
            mem_rdata_in = ~r;
            run(1'b1, 1'b0, 1'b0);
            `CHK(wr_seen, 1'b1)
            `CHK(wr_d, req_wdata_in)
            `CHK(wr_a, req_addr_in)
            run(1'b0, 1'b0, 1'b0);
            `CHK(rdata_out, mem_rdata_in)
            `CHK(waits_out, exp_waits(use_sync_in, wait_clks_in))
            `CHK(clocks_out, exp_clks(use_sync_in, wait_clks_in))
        end
        cache_hit_in = 1;
        cache_data_in = 32'h5a5a_1234;
        run(1'b0, 1'b0, 1'b0);
        `CHK({got_hit, seen_as, rdata_out}, {2'h2, cache_data_in})
        cache_hit_in = 0;
        run(1'b1, 1'b0, 1'b1);
        `CHK({got_abort, seen_as, wr_seen}, 3'h4)
        {use_sync_in, burst_ok_in, wait_clks_in} = {2'h3, 8'h00};
        run(1'b0, 1'b1, 1'b0);
        `CHK({got_done, beat_out, rdata_out}, {3'h7, mem_rdata_in})
        end_of_test;
    end
endmodule
